//--- ckg_host_model.sv
// Chipset-side model that writes configuration transfers over the two-wire serial port.
`timescale 1ns/1ns
`default_nettype none
module ckg_host_model (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // Both lines idle high on their pull-ups; the clock stands still between frames.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One clock pulse; data moves well clear of the falling clock edge.
  task automatic pulse(input logic b, output logic seen);
    #16 o_sda = b;
    #47 o_scl = 1'b1;
    #31 seen = i_sda;
    #31 o_scl = 1'b0;
  endtask : pulse
  // Start, ten bytes each with a released acknowledge slot, then stop.
  task automatic xfer(input logic [7:0] b [10], output int acks);
    logic s;
    acks = 0;
    o_sda = 1'b0;
    #62 o_scl = 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int k = 7; k >= 0; k--) pulse(b[i][k], s);
      pulse(1'b1, s);
      if (s === 1'b0) acks++;
    end
    #16 o_sda = 1'b0;
    #46 o_scl = 1'b1;
    #31 o_sda = 1'b1;
    #63;
  endtask : xfer
endmodule : ckg_host_model
`default_nettype wire

//--- ckg_pkg.sv
// Shared constants and types for the clock generator strap and serial configuration block.
package ckg_pkg;

  // Clock rate and derived timing.
  localparam int CLK_MHZ        = 250;
  localparam int STRAP_TIME_US  = 2000;
  localparam int STRAP_CYCLES   = STRAP_TIME_US * CLK_MHZ;
  localparam int RAMP_STEP_US   = 10;
  localparam int RAMP_STEP_CYC  = RAMP_STEP_US * CLK_MHZ;

  // Serial transfer framing.
  localparam logic [7:0] SLAVE_ADDR     = 8'hD2;
  localparam logic [3:0] XFER_BYTES     = 4'hA;
  localparam logic [3:0] FIRST_CFG_POS  = 4'h6;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // Clock output indices.
  localparam int NCLK       = 12;
  localparam int CLK_CPU0   = 0;
  localparam int CLK_PCI_F  = 2;
  localparam int CLK_USBSEL = 11;

  // Synchroniser lanes.
  localparam int SY_SCL   = 0;
  localparam int SY_SDA   = 1;
  localparam int SY_STRAP = 2;
  localparam int SY_PGOOD = 3;
  localparam int SY_RATE  = 4;
  localparam int SY_XTAL  = 5;
  localparam int SY_PLL   = 6;
  localparam int NSYNC    = SY_PLL + NCLK;

  // Register map, byte addresses.
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONFIG  = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;

  // Field positions and reset values.
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_STRAP_BIT = 1;
  localparam int STAT_TRI_BIT   = 2;
  localparam int STAT_TEST_BIT  = 3;
  localparam int STAT_CODE_LSB  = 4;
  localparam int STAT_CNT_LSB   = 16;
  localparam int CTRL_SEN_BIT   = 0;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic        CTRL_RESET = 1'b1;

  // Configuration bytes 3 to 6, byte 3 in the top lane.
  typedef struct packed {
    logic [3:0] freq_sel;
    logic [1:0] rsv3;
    logic       tristate;
    logic       test_mode;
    logic [7:0] dis_pci;
    logic [7:0] dis_misc;
    logic [7:0] rsv6;
  } ckg_cfg_t;

  // Power-up sequencing phases.
  typedef enum logic [1:0] {PH_WAIT_PWR, PH_SAMPLE, PH_LATCH, PH_RUN} ckg_phase_t;

endpackage : ckg_pkg

//--- ckg_top.sv
// Power-up strap sampling, serial configuration receiver and clock output control.
`timescale 1ns/1ns
`default_nettype none
module ckg_top #(
  parameter int P_STRAP_CYCLES = ckg_pkg::STRAP_CYCLES
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_POWER_GOOD,
  input  wire logic        I_REFERENCE_CLOCK_OUT,
  output logic             O_REFERENCE_CLOCK_OUT,
  output logic             O_REFERENCE_CLOCK_OUT_OE,
  input  wire logic        I_SERIAL_CLOCK_PIN,
  input  wire logic        I_SERIAL_DATA_PIN,
  output logic             O_SERIAL_DATA_PIN,
  output logic             O_SERIAL_DATA_PIN_OE,
  input  wire logic        I_CPU_RATE_SELECT_PIN,
  input  wire logic        I_CRYSTAL_REFERENCE_INPUT,
  input  wire logic [11:0] I_PLL_CLK,
  output logic      [11:0] O_CLK,
  output logic      [11:0] O_CLK_OE,
  output logic      [4:0]  O_PLL_CODE,
  output logic             O_FREQ_SETTLING,
  output logic             O_STRAP_RATE_SELECT
);

  // The timer cannot serve an empty sampling interval, so elaboration refuses one.
  if (P_STRAP_CYCLES < 1) begin : g_bad_strap
    $error("P_STRAP_CYCLES must be at least 1");
  end

  // Returns the next ramp code, one step toward the target.
  function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] tgt);
    logic [4:0] r;
    r = cur;
    if (cur < tgt) begin
      r = cur + 5'h01;
    end else if (cur > tgt) begin
      r = cur - 5'h01;
    end
    return r;
  endfunction : step_toward

  // Input synchronisers: three stages, a lane changes only when stages two and three agree.
  logic [ckg_pkg::NSYNC-1:0] sync1_q;
  logic [ckg_pkg::NSYNC-1:0] sync2_q;
  logic [ckg_pkg::NSYNC-1:0] sync3_q;
  logic [ckg_pkg::NSYNC-1:0] filt_q;
  logic [ckg_pkg::NSYNC-1:0] filt_prev_q;
  logic [ckg_pkg::NSYNC-1:0] raw_in;

  assign raw_in = {I_PLL_CLK, I_CRYSTAL_REFERENCE_INPUT, I_CPU_RATE_SELECT_PIN, I_POWER_GOOD,
                   I_REFERENCE_CLOCK_OUT, I_SERIAL_DATA_PIN, I_SERIAL_CLOCK_PIN};

  // Pins idle high on the serial lines, so every stage resets high there.
  // Resetting the stages to the idle level keeps a false clock edge out after reset.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sync1_q     <= 18'h00003;
      sync2_q     <= 18'h00003;
      sync3_q     <= 18'h00003;
      filt_q      <= 18'h00003;
      filt_prev_q <= 18'h00003;
    end else begin
      sync1_q     <= raw_in;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      filt_q      <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
      filt_prev_q <= filt_q;
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl        = filt_q[ckg_pkg::SY_SCL];
  assign sda        = filt_q[ckg_pkg::SY_SDA];
  assign scl_rise   = scl & ~filt_prev_q[ckg_pkg::SY_SCL];
  assign scl_fall   = ~scl & filt_prev_q[ckg_pkg::SY_SCL];
  assign start_cond = scl & filt_prev_q[ckg_pkg::SY_SCL] & ~sda & filt_prev_q[ckg_pkg::SY_SDA];
  assign stop_cond  = scl & filt_prev_q[ckg_pkg::SY_SCL] & sda & ~filt_prev_q[ckg_pkg::SY_SDA];

  // Power-up sequencer: wait for power-good, sample, latch, then run.
  ckg_pkg::ckg_phase_t phase_q;
  logic [31:0]         timer_q;
  logic                strap_q;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      phase_q <= ckg_pkg::PH_WAIT_PWR;
      timer_q <= 32'h0000_0000;
    end else begin
      case (phase_q)
        ckg_pkg::PH_WAIT_PWR: begin
          if (filt_q[ckg_pkg::SY_PGOOD]) begin
            phase_q <= ckg_pkg::PH_SAMPLE;
          end
        end
        ckg_pkg::PH_SAMPLE: begin
          if (timer_q == 32'(P_STRAP_CYCLES - 1)) begin
            phase_q <= ckg_pkg::PH_LATCH;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
        ckg_pkg::PH_LATCH: begin
          phase_q <= ckg_pkg::PH_RUN;
        end
        ckg_pkg::PH_RUN: begin
          phase_q <= ckg_pkg::PH_RUN;
        end
        default: begin
          phase_q <= ckg_pkg::PH_WAIT_PWR;
        end
      endcase
    end
  end

  // Strap latch: written once in the latch phase, cleared only by power-on reset.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      strap_q <= 1'b0;
    end else if (phase_q == ckg_pkg::PH_LATCH) begin
      strap_q <= filt_q[ckg_pkg::SY_STRAP];
    end
  end

  logic running;
  assign running             = (phase_q == ckg_pkg::PH_RUN);
  assign O_STRAP_RATE_SELECT = strap_q; // High asks the PLL for 24 MHz, low for 48 MHz.

  // Serial receiver state.
  logic        sen_q;
  logic        active_q;
  logic        addr_ok_q;
  logic        ack_q;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  pos_q;
  logic [7:0]  shift_q;
  logic [31:0] cfg_q;
  logic [15:0] xfer_cnt_q;
  logic [7:0]  rx_byte;
  logic        ack_this;

  // The completed byte is the seven bits held plus the one on this rising edge.
  assign rx_byte  = {shift_q[6:0], sda};
  assign ack_this = (pos_q == 4'h0) ? (rx_byte == ckg_pkg::SLAVE_ADDR) : addr_ok_q;

  // Bit and byte framing; START restarts the sequence, STOP ends it.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      active_q  <= 1'b0;
      addr_ok_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      pos_q     <= 4'h0;
      shift_q   <= 8'h00;
    end else if (start_cond) begin
      active_q  <= 1'b1;
      addr_ok_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      pos_q     <= 4'h0;
    end else if (stop_cond) begin
      active_q  <= 1'b0;
    end else if (active_q && scl_rise) begin
      if (bit_cnt_q == ckg_pkg::BITS_PER_BYTE) begin
        bit_cnt_q <= 4'h0;
      end else begin
        shift_q   <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q == ckg_pkg::BITS_PER_BYTE - 4'h1) begin
          if (pos_q == 4'h0) begin
            addr_ok_q <= (rx_byte == ckg_pkg::SLAVE_ADDR);
          end
          if (pos_q != ckg_pkg::XFER_BYTES) begin
            pos_q <= pos_q + 4'h1;
          end
        end
      end
    end
  end

  // Acknowledge pulls the data pin low for the ninth clock; no data ever goes back.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ack_q <= 1'b0;
    end else if (start_cond || stop_cond || !active_q) begin
      ack_q <= 1'b0;
    end else if (scl_fall) begin
      ack_q <= (bit_cnt_q == ckg_pkg::BITS_PER_BYTE) && addr_ok_q;
    end
  end

  assign O_SERIAL_DATA_PIN    = 1'b0;
  assign O_SERIAL_DATA_PIN_OE = ack_q;

  // Configuration bytes: positions 6 to 9 land in bytes 3 to 6, earlier positions are ignored.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cfg_q <= ckg_pkg::CFG_RESET;
    end else if (active_q && scl_rise && sen_q && ack_this
                 && (bit_cnt_q == ckg_pkg::BITS_PER_BYTE - 4'h1)
                 && (pos_q >= ckg_pkg::FIRST_CFG_POS) && (pos_q < ckg_pkg::XFER_BYTES)) begin
      case (pos_q - ckg_pkg::FIRST_CFG_POS)
        4'h0:    cfg_q[31:24] <= rx_byte;
        4'h1:    cfg_q[23:16] <= rx_byte;
        4'h2:    cfg_q[15:8]  <= rx_byte;
        default: cfg_q[7:0]   <= rx_byte;
      endcase
    end
  end

  // Counts complete transfers of ten or more bytes to this address, closed by STOP.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      xfer_cnt_q <= 16'h0000;
    end else if (stop_cond && active_q && addr_ok_q && (pos_q == ckg_pkg::XFER_BYTES)) begin
      xfer_cnt_q <= xfer_cnt_q + 16'h0001;
    end
  end

  // Reserved bits are stored as written; the host is expected to keep them zero.
  ckg_pkg::ckg_cfg_t cfg;
  assign cfg = ckg_pkg::ckg_cfg_t'(cfg_q);

  // Frequency code: a zero register field leaves the choice to the rate pin.
  logic [4:0]  target_code;
  logic [4:0]  cur_code_q;
  logic [11:0] step_cnt_q;
  logic        step_tick;

  assign target_code = (cfg.freq_sel != 4'h0) ? {1'b1, cfg.freq_sel}
                                              : {4'h0, filt_q[ckg_pkg::SY_RATE]};
  assign step_tick   = (step_cnt_q == 12'(ckg_pkg::RAMP_STEP_CYC - 1));

  // Once running, the ramp moves one code per step so the PLL never jumps; the CPU keeps running. Before that the code takes the target at once.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      step_cnt_q <= 12'h000;
      cur_code_q <= 5'h00;
    end else begin
      step_cnt_q <= step_tick ? 12'h000 : step_cnt_q + 12'h001;
      if (!running) begin
        cur_code_q <= target_code;
      end else if (step_tick) begin
        cur_code_q <= step_toward(cur_code_q, target_code);
      end
    end
  end

  assign O_PLL_CODE      = cur_code_q;
  assign O_FREQ_SETTLING = (cur_code_q != target_code);

  // Per-output disable vector in output index order.
  logic [11:0] dis_vec;
  logic [11:0] src_vec;
  assign dis_vec = {cfg.dis_misc[4:2], cfg.dis_pci[6:0], cfg.dis_misc[1:0]};
  assign src_vec = cfg.test_mode ? {12{filt_q[ckg_pkg::SY_XTAL]}}
                                 : filt_q[ckg_pkg::SY_PLL +: ckg_pkg::NCLK];

  // Clock outputs are registered; the first enabled cycle may be short.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_CLK    <= 12'h000;
      O_CLK_OE <= 12'h000;
    end else if (cfg.tristate) begin
      O_CLK    <= 12'h000;
      O_CLK_OE <= 12'h000;
    end else if (!running) begin
      O_CLK    <= 12'h000;
      O_CLK_OE <= 12'hFFF;
    end else begin
      O_CLK    <= src_vec & ~dis_vec;
      O_CLK_OE <= 12'hFFF;
    end
  end

  // Reference output: floats until the strap is latched, then copies the crystal.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_REFERENCE_CLOCK_OUT    <= 1'b0;
      O_REFERENCE_CLOCK_OUT_OE <= 1'b0;
    end else if (!running || cfg.tristate) begin
      O_REFERENCE_CLOCK_OUT    <= 1'b0;
      O_REFERENCE_CLOCK_OUT_OE <= 1'b0;
    end else begin
      O_REFERENCE_CLOCK_OUT    <= filt_q[ckg_pkg::SY_XTAL] & ~cfg.dis_misc[5];
      O_REFERENCE_CLOCK_OUT_OE <= 1'b1;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle.
  logic setup_ph;
  logic access_ph;
  logic addr_hit;
  assign setup_ph  = I_PSEL & ~I_PENABLE;
  assign access_ph = I_PSEL & I_PENABLE;
  assign addr_hit  = (I_PADDR == ckg_pkg::REG_STATUS) || (I_PADDR == ckg_pkg::REG_CONFIG)
                     || (I_PADDR == ckg_pkg::REG_CONTROL);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access_ph & ~addr_hit;

  // Control register: serial-port write enable.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sen_q <= ckg_pkg::CTRL_RESET;
    end else if (access_ph && I_PWRITE && (I_PADDR == ckg_pkg::REG_CONTROL)) begin
      sen_q <= I_PWDATA[ckg_pkg::CTRL_SEN_BIT];
    end
  end

  // Read mux; unmapped offsets read zero.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup_ph && !I_PWRITE) begin
      O_PRDATA <= 32'h0000_0000;
      case (I_PADDR)
        ckg_pkg::REG_STATUS: begin
          O_PRDATA[ckg_pkg::STAT_DONE_BIT]                 <= running;
          O_PRDATA[ckg_pkg::STAT_STRAP_BIT]                <= strap_q;
          O_PRDATA[ckg_pkg::STAT_TRI_BIT]                  <= cfg.tristate;
          O_PRDATA[ckg_pkg::STAT_TEST_BIT]                 <= cfg.test_mode;
          O_PRDATA[ckg_pkg::STAT_CODE_LSB +: 5]            <= cur_code_q;
          O_PRDATA[ckg_pkg::STAT_CNT_LSB +: 16]            <= xfer_cnt_q;
        end
        ckg_pkg::REG_CONFIG:  O_PRDATA                      <= cfg_q;
        ckg_pkg::REG_CONTROL: O_PRDATA[ckg_pkg::CTRL_SEN_BIT] <= sen_q;
        default:              O_PRDATA                      <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ckg_top
`default_nettype wire

//--- ckg_top_asserts.sv
// Concurrent checks on the strap, serial and ramp outputs of the clock generator.
`timescale 1ns/1ns
`default_nettype none
module ckg_top_asserts #(parameter int P_STRAP_CYCLES = ckg_pkg::STRAP_CYCLES) (
  input wire logic        I_MCLK,
  input wire logic        I_RST,
  input wire logic        I_POWER_GOOD,
  input wire logic        O_REFERENCE_CLOCK_OUT_OE,
  input wire logic        O_SERIAL_DATA_PIN,
  input wire logic        O_SERIAL_DATA_PIN_OE,
  input wire logic [11:0] O_CLK_OE,
  input wire logic [4:0]  O_PLL_CODE,
  input wire logic        O_STRAP_RATE_SELECT
);
  logic [31:0] pg_q;
  logic [7:0]  ack_q;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // Power-good time so far; the raw pin leads the design's synchroniser, so this is safe.
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !I_POWER_GOOD) pg_q <= 32'h0;
    else if (pg_q < P_STRAP_CYCLES) pg_q <= pg_q + 32'h1;
  end
  // Length of the current data drive; a long one would mean data is being returned.
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !O_SERIAL_DATA_PIN_OE) ack_q <= 8'h0;
    else if (ack_q != 8'hFF) ack_q <= ack_q + 8'h1;
  end
  sequence s_step;
    $changed(O_PLL_CODE);
  endsequence
  sequence s_latch;
    $changed(O_STRAP_RATE_SELECT);
  endsequence
  chk_hiz_while_sample: assert property (
    $rose(O_REFERENCE_CLOCK_OUT_OE) |-> pg_q >= P_STRAP_CYCLES)
    else $error("reference pin driven before the sampling time ran out");
  chk_latch_then_drive: assert property (s_latch |=> $rose(O_REFERENCE_CLOCK_OUT_OE))
    else $error("reference buffer not enabled right after the strap latch");
  chk_strap_hold: assert property (
    O_REFERENCE_CLOCK_OUT_OE |-> $stable(O_STRAP_RATE_SELECT))
    else $error("latched strap changed while running");
  chk_sda_low_only: assert property (O_SERIAL_DATA_PIN == 1'b0)
    else $error("serial data driven high");
  chk_ack_short: assert property (O_SERIAL_DATA_PIN_OE |-> ack_q < 8'd64)
    else $error("serial data driven beyond one bit slot");
  chk_ramp_unit: assert property (s_step |->
    O_PLL_CODE == $past(O_PLL_CODE) + 5'h01 || O_PLL_CODE == $past(O_PLL_CODE) - 5'h01)
    else $error("frequency code jumped by more than one step");
  chk_ramp_hold: assert property (s_step |=> $stable(O_PLL_CODE) [*8])
    else $error("frequency code stepped twice in quick succession");
  chk_tri_all_off: assert property (
    $fell(O_REFERENCE_CLOCK_OUT_OE) |-> O_CLK_OE == 12'h000)
    else $error("reference floated while clock outputs still driven");
endmodule : ckg_top_asserts
bind ckg_top ckg_top_asserts #(.P_STRAP_CYCLES(P_STRAP_CYCLES)) u_chk (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_POWER_GOOD(I_POWER_GOOD),
  .O_REFERENCE_CLOCK_OUT_OE(O_REFERENCE_CLOCK_OUT_OE), .O_SERIAL_DATA_PIN(O_SERIAL_DATA_PIN),
  .O_SERIAL_DATA_PIN_OE(O_SERIAL_DATA_PIN_OE), .O_CLK_OE(O_CLK_OE), .O_PLL_CODE(O_PLL_CODE),
  .O_STRAP_RATE_SELECT(O_STRAP_RATE_SELECT));
`default_nettype wire

//--- ckg_top_test.sv
// Self-checking testbench for the clock generator strap and serial configuration block.
`timescale 1ns/1ns
`default_nettype none
module ckg_top_test;
  localparam int STRAP = 50;
  logic        clk, rst, psel, pen, pwr, pg, strap, rate, xtal, hscl, hsda;
  logic        pready, pslverr, ref_out, ref_oe, sda_out, sda_oe, settle, strap_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, old;
  logic [11:0] pll, oclk, oclk_oe;
  logic [4:0]  code;
  logic [64:0] expq [$];
  logic [64:0] e;
  logic [7:0]  cfg [4];
  int          failures, total_checks, cyc, n, acks;
  wire         ref_pin = ref_oe ? ref_out : strap;
  wire         sda_w = hsda & (sda_oe ? sda_out : 1'b1);
  wire  [12:0] outs = {ref_out, oclk};
  // System clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ckg_top #(.P_STRAP_CYCLES(STRAP)) i_dut (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_POWER_GOOD(pg), .I_REFERENCE_CLOCK_OUT(ref_pin),
    .O_REFERENCE_CLOCK_OUT(ref_out), .O_REFERENCE_CLOCK_OUT_OE(ref_oe),
    .I_SERIAL_CLOCK_PIN(hscl), .I_SERIAL_DATA_PIN(sda_w), .O_SERIAL_DATA_PIN(sda_out),
    .O_SERIAL_DATA_PIN_OE(sda_oe), .I_CPU_RATE_SELECT_PIN(rate),
    .I_CRYSTAL_REFERENCE_INPUT(xtal), .I_PLL_CLK(pll), .O_CLK(oclk), .O_CLK_OE(oclk_oe),
    .O_PLL_CODE(code), .O_FREQ_SETTLING(settle), .O_STRAP_RATE_SELECT(strap_q));
  ckg_host_model i_host (.o_scl(hscl), .o_sda(hsda), .i_sda(sda_w));
  // Free-running PLL and crystal levels, and the cut-off for a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) pll <= ~pll;
    if (cyc % 9 == 8) xtal <= ~xtal;
    if (cyc == 90000) begin
      failures++;
      end_of_test();
    end
  end
  // Each completed read takes the oldest note and compares masked data and error.
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr) begin
      e = expq.pop_front();
      check({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : check
  // One APB transfer; a read leaves its expectation for the monitor.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic er);
    if (!w) expq.push_back({er, m, d});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Counts level changes of one output over 72 cycles; index 12 is the reference pin.
  task automatic edges(input int idx, output int cnt);
    logic p;
    cnt = 0;
    p = outs[idx];
    repeat (72) begin
      @(posedge clk);
      if (outs[idx] !== p) cnt++;
      p = outs[idx];
    end
  endtask : edges
  // Serial write of cfg behind random command, count and unused bytes.
  task automatic ser(input logic [7:0] a, input int want);
    logic [7:0] b [10];
    b[0] = a;
    for (int i = 1; i < 6; i++) b[i] = 8'($urandom);
    for (int i = 0; i < 4; i++) b[6 + i] = cfg[i];
    i_host.xfer(b, acks);
    check(acks, want);
    @(posedge clk);
  endtask : ser
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Main sequence; reserved configuration bits are always sent as zero.
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, pg, xtal, pll, cyc} = {1'b1, 57'h0, 32'h0};
    void'($urandom(32'h5542428F));
    strap = 1'($urandom);
    rate = 1'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({ref_oe, strap_q, oclk_oe, oclk}, {2'b00, 12'hFFF, 12'h000});
    apb(0, 8'h08, 32'h1, 32'hFFFFFFFF, 0);
    apb(0, 8'h04, 32'h0, 32'hFFFFFFFF, 0);
    apb(0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1);
    repeat (20) @(posedge clk);
    check(ref_oe, 1'b0);
    pg <= 1'b1;
    n = 0;
    while (ref_oe !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check(n >= STRAP && n <= STRAP + 8, 1'b1);
    check(strap_q, strap);
    apb(0, 8'h00, {30'h0, strap, 1'b1}, 32'h3, 0);
    edges(12, n);
    check(n >= 7 && n <= 9, 1'b1);
    check(oclk_oe, 12'hFFF);
    cfg = '{8'h00, {1'b0, 7'($urandom)}, {2'b00, 6'($urandom) & 6'h3D | 6'h01}, 8'h00};
    ser(8'hD2, 10);
    old = {cfg[0], cfg[1], cfg[2], cfg[3]};
    apb(0, 8'h04, old, 32'hFFFFFFFF, 0);
    apb(0, 8'h00, 32'h0001_0000, 32'hFFFF_0000, 0);
    edges(0, n);
    check({n, oclk[0], oclk_oe[0]}, {32'h0, 2'b01});
    edges(1, n);
    check(n >= 30, 1'b1);
    check(strap_q, strap);
    cfg[1] = ~cfg[1] & 8'h7F;
    ser(8'hD2 ^ (8'h01 << $urandom_range(7, 0)), 0);
    apb(0, 8'h04, old, 32'hFFFFFFFF, 0);
    apb(1, 8'h08, 32'h0, 32'h0, 0);
    ser(8'hD2, 10);
    apb(0, 8'h04, old, 32'hFFFFFFFF, 0);
    apb(1, 8'h08, 32'h1, 32'h0, 0);
    cfg = '{8'h02, 8'h00, 8'h00, 8'h00};
    ser(8'hD2, 10);
    check({ref_oe, oclk_oe}, 13'h0);
    cfg[0] = 8'h01;
    ser(8'hD2, 10);
    edges(1, n);
    check(n >= 6 && n <= 10, 1'b1);
    cfg[0] = 8'h10;
    ser(8'hD2, 10);
    check(settle, 1'b1);
    n = 0;
    while (code !== 5'h11 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    check(n >= (15 - rate) * 2500 && n <= (17 - rate) * 2500, 1'b1);
    check(settle, 1'b0);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({strap_q, ref_oe}, 2'b00);
    end_of_test();
  end
endmodule : ckg_top_test
`default_nettype wire
